/* File: bpc_cfg.svh */
// timing and encoding constants of the buck pwm control and protection block
// assumes a 100 MHz logic clock
`ifndef BPC_CFG_SVH
`define BPC_CFG_SVH
`define BPC_CLK_MHZ          100
`define BPC_FREQ_LO_KHZ      350
`define BPC_FREQ_HI_KHZ      550
`define BPC_FREQ_MIN_KHZ     280
`define BPC_FREQ_MAX_KHZ     700
`define BPC_RT_NUM_KHZ_KOHM  50000
`define BPC_BLANK_NS         100
`define BPC_BLANK_CYC        ((`BPC_BLANK_NS * `BPC_CLK_MHZ + 999) / 1000)
`define BPC_TRIP_NS          100
`define BPC_TRIP_CYC         ((`BPC_TRIP_NS * `BPC_CLK_MHZ + 999) / 1000)
`define BPC_OC_OFF_NS        200
`define BPC_OC_OFF_CYC       ((`BPC_OC_OFF_NS * `BPC_CLK_MHZ) / 1000)
`define BPC_INPUT_LOCKOUT_DG_NS       2500
`define BPC_INPUT_LOCKOUT_DG_CYC      ((`BPC_INPUT_LOCKOUT_DG_NS * `BPC_CLK_MHZ + 999) / 1000)
`define BPC_PG_DG_NS         35000
`define BPC_PG_DG_CYC        ((`BPC_PG_DG_NS * `BPC_CLK_MHZ + 999) / 1000)
`define BPC_SS_NS            3350000
`define BPC_SS_CYC           ((`BPC_SS_NS * `BPC_CLK_MHZ) / 1000)
`define BPC_OSC_PULSE_CYC    20
`define BPC_REF_FULL         16'h0FFF
`endif

/* File: bpc_ctrl.sv */
// buck switching-cycle control: oscillator, pulse-width latch, dead time, protection
// assumes analog comparator results arrive as logic levels and are synchronised here
//
// What this block does
// - resistor open: 350 kHz on select low/float, 550 kHz on select high
// - resistor fitted, select floating: rate 50000/R kHz, 280 to 700 kHz
// - oscillator pulse sets latch, ramp comparator resets it, alternating each cycle
// - low side stays on through oscillator pulse, then high side turns on
// - ramp above error amp resets latch: high off, low on until next pulse
// - error amp above ramp peak: high side on until oscillator pulse
// - error amp below valley: latch set by each pulse, reset once the pulse ends, low side stays on
// - current limit tripped over 100 ns resets latch early, every such cycle
// - high side off within 200 ns of reaching current threshold
// - current limit ignored for 100 ns at each high-side leading edge
// - current limit only acts while sourcing from supply to phase node
// - high side enabled only after low-side gate is below 2 V
// - over 150 C both switches off and controller disabled
// - leave shutdown 10 C below trip, restart through slow-start, repeat
// - power good low when sense falls 10 percent below reference
// - power good also low in lockout, enable low, or thermal shutdown
// - power good high only with supply, enable and sense above 90 percent
// - power good comparator 3 percent hysteresis, 35 us falling deglitch
// - lockout rises 2.95 V, falls 2.8 V, both edges deglitched 2.5 us
// - slow-start ramps reference linearly 0 to full over 3.35 ms
`timescale 1ns/100ps
`include "bpc_cfg.svh"
module bpc_ctrl
#(
  parameter int SS_CYC     = `BPC_SS_CYC,
  parameter int PG_DG_CYC  = `BPC_PG_DG_CYC,
  parameter int UV_DG_CYC  = `BPC_INPUT_LOCKOUT_DG_CYC
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        freq_select_input,
  input  wire logic        freq_select_float,
  input  wire logic        timing_resistor_open,
  input  wire logic [15:0] timing_resistor_kohm,
  input  wire logic        ramp_above_ea,
  input  wire logic        current_limit_cmp,
  input  wire logic        sourcing_current,
  input  wire logic        low_gate_below_2v,
  input  wire logic        temp_over_trip,
  input  wire logic        temp_below_release,
  input  wire logic        input_lockout_rise_cmp,
  input  wire logic        input_lockout_fall_cmp,
  input  wire logic        soft_start_enable,
  input  wire logic        sense_below_pg_cmp,
  input  wire logic        sense_above_pg_hyst_cmp,
  output logic             high_gate_en,
  output logic             low_gate_en,
  output logic             osc_pulse,
  output logic [15:0]      slow_start_ref,
  output logic             power_good_output_o,
  output logic             power_good_output_oe_n,
  output bpc_pkg::bpc_state_e ctrl_state,
  output bpc_pkg::bpc_src_e   freq_source
);
  import bpc_pkg::*;

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  localparam int NSY = 12;
  logic [NSY-1:0] sy_in;
  logic [NSY-1:0] sy1_reg;
  logic [NSY-1:0] sy2_reg;
  assign sy_in = {freq_select_input, ramp_above_ea, current_limit_cmp, sourcing_current,
                  low_gate_below_2v, temp_over_trip, temp_below_release,
                  input_lockout_rise_cmp, input_lockout_fall_cmp, soft_start_enable,
                  sense_below_pg_cmp, sense_above_pg_hyst_cmp};
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sy1_reg <= '0;
      sy2_reg <= '0;
    end
    else
    begin
      sy1_reg <= sy_in;
      sy2_reg <= sy1_reg;
    end
  end
  logic s_freq_select_input, s_ramp, s_ilim, s_src, s_lg2v, s_thot, s_tcool;
  logic s_uvr, s_uvf, s_ena, s_pglo, s_pghi;
  assign {s_freq_select_input, s_ramp, s_ilim, s_src, s_lg2v, s_thot, s_tcool,
          s_uvr, s_uvf, s_ena, s_pglo, s_pghi} = sy2_reg;

  // ----------------------------------------------------------------
  // frequency selection
  // ----------------------------------------------------------------
  function automatic logic [19:0] bpc_period(input logic [31:0] khz);
    logic [31:0] p;
    p = (`BPC_CLK_MHZ * 1000) / ((khz == 0) ? 32'd1 : khz);
    return p[19:0];
  endfunction : bpc_period

  logic [31:0] res_khz;
  logic [31:0] res_lim;
  logic [19:0] period;
  always_comb
  begin
    res_khz = `BPC_RT_NUM_KHZ_KOHM / ((timing_resistor_kohm == 16'h0000) ? 32'd1
              : {16'h0000, timing_resistor_kohm});
    res_lim = res_khz;
    if (res_khz < `BPC_FREQ_MIN_KHZ)
      res_lim = `BPC_FREQ_MIN_KHZ;
    if (res_khz > `BPC_FREQ_MAX_KHZ)
      res_lim = `BPC_FREQ_MAX_KHZ;
    if (timing_resistor_open)
    begin
      freq_source = BPC_SRC_INT;
      period = s_freq_select_input ? bpc_period(`BPC_FREQ_HI_KHZ) : bpc_period(`BPC_FREQ_LO_KHZ);
    end
    else if (freq_select_float)
    begin
      freq_source = BPC_SRC_RES;
      period = bpc_period(res_lim);
    end
    else
    begin
      freq_source = BPC_SRC_SYNC;
      period = bpc_period(res_lim * 100 / 80); // free-run fallback
    end
  end

  // ----------------------------------------------------------------
  // oscillator; in sync mode a rising select edge restarts the cycle
  // ----------------------------------------------------------------
  logic [19:0] osc_cnt_reg;
  logic        freq_select_input_d_reg;
  logic        sync_edge;
  assign sync_edge = (freq_source == BPC_SRC_SYNC) && s_freq_select_input && !freq_select_input_d_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_cnt_reg <= 20'h00000;
      freq_select_input_d_reg  <= 1'b0;
    end
    else
    begin
      freq_select_input_d_reg <= s_freq_select_input;
      if (sync_edge || osc_cnt_reg + 20'h00001 >= period)
        osc_cnt_reg <= 20'h00000;
      else
        osc_cnt_reg <= osc_cnt_reg + 20'h00001;
    end
  end
  logic osc_set;
  assign osc_set = (osc_cnt_reg == 20'h00000);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      osc_pulse <= 1'b0;
    else
      osc_pulse <= (osc_cnt_reg < 20'(`BPC_OSC_PULSE_CYC));
  end

  // ----------------------------------------------------------------
  // lockout deglitch on both edges
  // ----------------------------------------------------------------
  logic        uv_ok_reg;
  logic [15:0] uv_cnt_reg;
  logic        uv_want;
  assign uv_want = uv_ok_reg ? s_uvf : s_uvr;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      uv_ok_reg  <= 1'b0;
      uv_cnt_reg <= 16'h0000;
    end
    else if (uv_want == uv_ok_reg)
      uv_cnt_reg <= 16'h0000;
    else if (uv_cnt_reg >= 16'(UV_DG_CYC - 1))
    begin
      uv_ok_reg  <= uv_want;
      uv_cnt_reg <= 16'h0000;
    end
    else
      uv_cnt_reg <= uv_cnt_reg + 16'h0001;
  end

  // ----------------------------------------------------------------
  // control state and slow-start
  // ----------------------------------------------------------------
  bpc_state_e  st_reg;
  logic [23:0] ss_cnt_reg;
  logic        enabled;
  assign enabled = uv_ok_reg && s_ena;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= BPC_ST_OFF;
    else
      unique case (st_reg)
        BPC_ST_OFF: if (enabled) st_reg <= BPC_ST_SS;
        BPC_ST_SS:
          if (!enabled)                       st_reg <= BPC_ST_OFF;
          else if (s_thot)                    st_reg <= BPC_ST_TSD;
          else if (ss_cnt_reg >= 24'(SS_CYC)) st_reg <= BPC_ST_RUN;
        BPC_ST_RUN:
          if (!enabled)    st_reg <= BPC_ST_OFF;
          else if (s_thot) st_reg <= BPC_ST_TSD;
        BPC_ST_TSD:
          if (s_tcool) st_reg <= BPC_ST_OFF; // restart via slow-start
        default: st_reg <= BPC_ST_OFF;
      endcase
  end
  assign ctrl_state = st_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ss_cnt_reg <= 24'h000000;
    else if (st_reg == BPC_ST_SS && ss_cnt_reg < 24'(SS_CYC))
      ss_cnt_reg <= ss_cnt_reg + 24'h000001;
    else if (st_reg == BPC_ST_OFF || st_reg == BPC_ST_TSD)
      ss_cnt_reg <= 24'h000000;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      slow_start_ref <= 16'h0000;
    else
      slow_start_ref <= 16'((40'(ss_cnt_reg) * 40'(`BPC_REF_FULL)) / 40'(SS_CYC));
  end

  // ----------------------------------------------------------------
  // current limit with blanking and trip filter
  // ----------------------------------------------------------------
  logic       active;
  logic [7:0] blank_cnt_reg;
  logic [7:0] trip_cnt_reg;
  logic       ilim_trip;
  logic       pwm_latch_reg;
  assign active = (st_reg == BPC_ST_SS) || (st_reg == BPC_ST_RUN);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      blank_cnt_reg <= 8'h00;
    else if (!high_gate_en)
      blank_cnt_reg <= 8'h00;
    else if (blank_cnt_reg < 8'(`BPC_BLANK_CYC))
      blank_cnt_reg <= blank_cnt_reg + 8'h01;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      trip_cnt_reg <= 8'h00;
    else if (high_gate_en && s_ilim && s_src && blank_cnt_reg >= 8'(`BPC_BLANK_CYC))
    begin
      if (trip_cnt_reg < 8'(`BPC_TRIP_CYC))
        trip_cnt_reg <= trip_cnt_reg + 8'h01;
    end
    else
      trip_cnt_reg <= 8'h00;
  end
  assign ilim_trip = (trip_cnt_reg >= 8'(`BPC_TRIP_CYC));

  // ----------------------------------------------------------------
  // pulse-width latch and gates
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pwm_latch_reg <= 1'b0;
    else if (!active)
      pwm_latch_reg <= 1'b0;
    else if (osc_set)
      pwm_latch_reg <= 1'b1;
    else if ((s_ramp && !osc_pulse) || ilim_trip)
      pwm_latch_reg <= 1'b0; // ramp ignored in pulse
  end
  // high side only after the oscillator pulse ends, stays on to next pulse if never reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      high_gate_en <= 1'b0;
      low_gate_en  <= 1'b0;
    end
    else
    begin
      high_gate_en <= active && pwm_latch_reg && !osc_pulse && !osc_set && !s_ramp
                      && !ilim_trip && s_lg2v && !low_gate_en;
      low_gate_en  <= active && !(pwm_latch_reg && !osc_pulse && !osc_set && !s_ramp
                      && !ilim_trip);
    end
  end

  a_gate_overlap: assert property (@(posedge clk) disable iff (!rst_n)
    !(high_gate_en && low_gate_en)) else $error("both gates enabled");
  a_inactive_off: assert property (@(posedge clk) disable iff (!rst_n)
    !active |=> !high_gate_en ##0 !pwm_latch_reg) else $error("gate on while inactive");
  a_ilim_off: assert property (@(posedge clk) disable iff (!rst_n)
    ilim_trip |-> ##[1:2] !high_gate_en) else $error("current limit too slow");
  a_osc_sets: assert property (@(posedge clk) disable iff (!rst_n)
    active && osc_set |=> pwm_latch_reg) else $error("latch not set by oscillator");
  a_blank_hold: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(high_gate_en) |-> !ilim_trip [*8]) else $error("trip inside blanking");
  a_tsd_off: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg == BPC_ST_TSD |-> ##1 !high_gate_en) else $error("gate in thermal shutdown");

  // ----------------------------------------------------------------
  // power good with rising hysteresis and falling deglitch
  // ----------------------------------------------------------------
  logic        pg_reg;
  logic [15:0] pg_cnt_reg;
  logic        pg_force_low;
  assign pg_force_low = !uv_ok_reg || !s_ena || st_reg == BPC_ST_TSD;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pg_reg     <= 1'b0;
      pg_cnt_reg <= 16'h0000;
    end
    else if (pg_force_low)
    begin
      pg_reg     <= 1'b0;
      pg_cnt_reg <= 16'h0000;
    end
    else if (!pg_reg)
    begin
      pg_cnt_reg <= 16'h0000;
      if (s_pghi && !s_pglo)
        pg_reg <= 1'b1;
    end
    else if (s_pglo)
    begin
      if (pg_cnt_reg >= 16'(PG_DG_CYC - 1))
        pg_reg <= 1'b0;
      else
        pg_cnt_reg <= pg_cnt_reg + 16'h0001;
    end
    else
      pg_cnt_reg <= 16'h0000;
  end
  assign power_good_output_o    = 1'b0;
  assign power_good_output_oe_n = pg_reg; // low enable pulls the pin low

  a_pg_forced: assert property (@(posedge clk) disable iff (!rst_n)
    pg_force_low |=> !pg_reg) else $error("power good high while forced low");
  a_pg_deglitch: assert property (@(posedge clk) disable iff (!rst_n)
    pg_reg && s_pglo && !pg_force_low && pg_cnt_reg == 16'h0000 |=> pg_reg)
    else $error("power good fell without deglitch");
endmodule : bpc_ctrl

/* File: bpc_ctrl_tb_top.sv */
// self-checking bench of the buck switching-cycle control block
// assumes bpc_ctrl with shortened counts and bpc_stage_model as the power stage
`timescale 1ns/100ps
module bpc_ctrl_tb_top;
  import bpc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, sel_lvl = 1'b0, sel_flt = 1'b1, res_open = 1'b1;
  logic sync_on = 1'b0, sel_in = 1'b0, ramp_ab, cl, src_cur, below2v;
  logic lk_rise = 1'b0, lk_fall = 1'b0, ena = 1'b0, pg_blw = 1'b0, pg_abv = 1'b1;
  logic t_over = 1'b0, t_rel = 1'b1, ea_low = 1'b0, oc = 1'b0, sink = 1'b0, stuck = 1'b0;
  logic [15:0] kohm = 16'h0064, ea_thr = 16'h003C, ss_ref;
  logic hi, lo, osc, pg_o, pg_oe_n;
  bpc_state_e st;
  bpc_src_e   fsrc;
  int n_errors = 0, num_checks = 0, cyc = 0, overlap = 0, sync_cnt = 0;
  int per, hi_n, lo_n, pul_n, hp_n, h1;

  always #5 clk = ~clk;

  bpc_ctrl #(.SS_CYC(200), .PG_DG_CYC(20), .UV_DG_CYC(4)) bpc_ctrl_i (
    .clk(clk), .rst_n(rst_n), .freq_select_input(sel_in), .freq_select_float(sel_flt),
    .timing_resistor_open(res_open), .timing_resistor_kohm(kohm), .ramp_above_ea(ramp_ab),
    .current_limit_cmp(cl), .sourcing_current(src_cur), .low_gate_below_2v(below2v),
    .temp_over_trip(t_over), .temp_below_release(t_rel), .input_lockout_rise_cmp(lk_rise),
    .input_lockout_fall_cmp(lk_fall), .soft_start_enable(ena), .sense_below_pg_cmp(pg_blw),
    .sense_above_pg_hyst_cmp(pg_abv), .high_gate_en(hi), .low_gate_en(lo), .osc_pulse(osc),
    .slow_start_ref(ss_ref), .power_good_output_o(pg_o), .power_good_output_oe_n(pg_oe_n),
    .ctrl_state(st), .freq_source(fsrc));

  bpc_stage_model bpc_stage_model_i (
    .clk(clk), .high_gate_en(hi), .low_gate_en(lo), .osc_pulse(osc), .ea_thr(ea_thr),
    .ea_low(ea_low), .oc_force(oc), .sink_mode(sink), .gate_stuck(stuck),
    .ramp_above_ea(ramp_ab), .current_limit_cmp(cl), .sourcing_current(src_cur),
    .low_gate_below_2v(below2v));

  // outside sync source: 230-cycle clock, a little faster than the 235-cycle free run
  always @(posedge clk)
  begin
    sync_cnt <= (sync_cnt == 229) ? 0 : sync_cnt + 1;
    sel_in   <= sync_on ? (sync_cnt < 115) : sel_lvl;
  end

  task automatic complete_run;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask : complete_run

  always @(negedge clk)
  begin
    cyc++;
    if (hi === 1'b1 && lo === 1'b1)
      overlap++;
    if (cyc == 60000)
    begin
      n_errors++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input int tol);
    logic [31:0] d;
    begin
      d = (seen > exp) ? seen - exp : exp - seen;
      num_checks++;
      if ((^seen === 1'bx) || d > tol)
      begin
        n_errors++;
        $display("MISMATCH t=%0t seen %0d expected %0d", $time, seen, exp);
      end
    end
  endtask : check

  task automatic wait_st(input bpc_state_e s, input int lim);
    int i;
    begin
      for (i = 0; i < lim && st !== s; i++)
        @(negedge clk);
      check(32'(st), 32'(s), 0);
    end
  endtask : wait_st

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // one switching period from osc rise to the next osc rise
  task automatic measure;
    int i;
    begin
      per = 0; hi_n = 0; lo_n = 0; pul_n = 0; hp_n = 0;
      for (i = 0; i < 2000 && osc !== 1'b0; i++) @(negedge clk);
      for (i = 0; i < 2000 && osc !== 1'b1; i++) @(negedge clk);
      do
      begin
        per++; hi_n += hi; lo_n += lo; pul_n += osc; hp_n += (hi & osc);
        @(negedge clk);
      end while (per < 2000 && !(osc === 1'b1 && per > pul_n));
    end
  endtask : measure

  task automatic set_in(input logic [15:0] thr, input logic el, input logic o, input logic s);
    @(posedge clk);
    ea_thr <= thr; ea_low <= el; oc <= o; sink <= s;
    measure();
    measure();
  endtask : set_in

  logic [2:0]  ft_cfg [8] = '{3'h5, 3'h1, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4, 3'h0};
  logic [15:0] ft_r   [8] = '{16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h00B4,
                              16'h0044, 16'h0032, 16'h0093};
  int khz;

  initial
  begin
    idle(16);
    check({hi, lo, pg_oe_n}, 0, 0);
    check(32'(st), 32'(BPC_ST_OFF), 0);
    @(posedge clk);
    rst_n <= 1'b1;
    lk_rise <= 1'b1; lk_fall <= 1'b1;
    idle(50);
    check({hi, lo, pg_oe_n}, 0, 0);
    @(posedge clk);
    ena <= 1'b1;
    wait_st(BPC_ST_SS, 30);
    idle(100);
    check(ss_ref, 16'h0800, 16'h0100);
    wait_st(BPC_ST_RUN, 150);
    check(ss_ref, 16'h0FFF, 0);
    check({pg_o, pg_oe_n}, 1, 0);
    $display("test startup done");
    // cfg bits: float, level, resistor open
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk);
      {sel_flt, sel_lvl, res_open} <= ft_cfg[k];
      kohm <= ft_r[k];
      sync_on <= (k == 7);
      khz = ft_cfg[k][0] ? (ft_cfg[k][1] ? 550 : 350) : 50000 / int'(ft_r[k]);
      khz = (khz < 280) ? 280 : (khz > 700) ? 700 : khz;
      measure();
      measure();
      check(32'(fsrc), ft_cfg[k][0] ? 0 : ft_cfg[k][2] ? 1 : 2, 0);
      check(per, (k == 7) ? 230 : 100000 / khz, 2);
    end
    @(posedge clk);
    {sel_flt, sel_lvl, res_open, sync_on} <= 4'hA;
    $display("test frequency done");
    set_in(16'h003C, 1'b0, 1'b0, 1'b0);
    h1 = hi_n;
    set_in(16'h0078, 1'b0, 1'b0, 1'b0);
    check(hi_n - h1, 60, 3);
    check(pul_n, 20, 0);
    check(hp_n, 0, 0);
    check(hi_n + lo_n, per, 10);
    set_in(16'hFFFF, 1'b0, 1'b0, 1'b0);
    h1 = hi_n;
    check(lo_n, 25, 8);
    set_in(16'h003C, 1'b1, 1'b0, 1'b0);
    check(hi_n, 0, 0);
    check(lo_n, per, 0);
    set_in(16'hFFFF, 1'b0, 1'b1, 1'b0);
    check(hi_n, 22, 12);
    measure();
    check(hi_n, 22, 12);
    set_in(16'hFFFF, 1'b0, 1'b1, 1'b1);
    check(hi_n, h1, 3);
    @(posedge clk);
    stuck <= 1'b1;
    set_in(16'h003C, 1'b0, 1'b0, 1'b0);
    check(hi_n, 0, 0);
    @(posedge clk);
    stuck <= 1'b0;
    $display("test pwm done");
    @(posedge clk);
    {pg_blw, pg_abv} <= 2'h2;
    idle(10);
    @(posedge clk);
    {pg_blw, pg_abv} <= 2'h1;
    idle(30);
    check(pg_oe_n, 1, 0);
    @(posedge clk);
    {pg_blw, pg_abv} <= 2'h2;
    idle(30);
    check(pg_oe_n, 0, 0);
    @(posedge clk);
    pg_blw <= 1'b0;
    idle(30);
    check(pg_oe_n, 0, 0);
    @(posedge clk);
    pg_abv <= 1'b1;
    idle(6);
    check({pg_o, pg_oe_n}, 1, 0);
    $display("test power good done");
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      t_over <= 1'b1; t_rel <= 1'b0;
      wait_st(BPC_ST_TSD, 10);
      idle(4);
      check({hi, lo, pg_oe_n}, 0, 0);
      @(posedge clk);
      t_over <= 1'b0; t_rel <= 1'b1;
      wait_st(BPC_ST_SS, 20);
      wait_st(BPC_ST_RUN, 230);
    end
    $display("test thermal done");
    @(posedge clk);
    ena <= 1'b0;
    wait_st(BPC_ST_OFF, 300);
    idle(4);
    check({hi, lo, pg_oe_n}, 0, 0);
    @(posedge clk);
    ena <= 1'b1;
    wait_st(BPC_ST_SS, 30);
    @(posedge clk);
    lk_rise <= 1'b0; lk_fall <= 1'b0;
    idle(3);
    check(32'(st), 32'(BPC_ST_SS), 0);
    wait_st(BPC_ST_OFF, 14);
    idle(4);
    check({hi, lo, pg_oe_n}, 0, 0);
    check(overlap, 0, 0);
    $display("test shutdown done");
    complete_run();
  end
endmodule : bpc_ctrl_tb_top

/* File: bpc_pkg.sv */
// types shared by the buck pwm control and protection block
// assumes bpc_cfg.svh for numeric constants
package bpc_pkg;
  typedef enum logic [1:0] {
    BPC_SRC_INT    = 2'h0,
    BPC_SRC_RES    = 2'h1,
    BPC_SRC_SYNC   = 2'h2
  } bpc_src_e;
  typedef enum logic [3:0] {
    BPC_ST_OFF  = 4'h1,
    BPC_ST_SS   = 4'h2,
    BPC_ST_RUN  = 4'h4,
    BPC_ST_TSD  = 4'h8
  } bpc_state_e;
endpackage : bpc_pkg

/* File: bpc_stage_model.sv */
// far-side stand-in: gate drivers, pwm ramp comparator and current sense
// assumes gate enables from bpc_ctrl; the bench sets the analog operating point
`timescale 1ns/100ps
module bpc_stage_model
(
  input  wire logic        clk,
  input  wire logic        high_gate_en,
  input  wire logic        low_gate_en,
  input  wire logic        osc_pulse,
  input  wire logic [15:0] ea_thr,
  input  wire logic        ea_low,
  input  wire logic        oc_force,
  input  wire logic        sink_mode,
  input  wire logic        gate_stuck,
  output logic             ramp_above_ea,
  output logic             current_limit_cmp,
  output logic             sourcing_current,
  output logic             low_gate_below_2v
);
  logic [15:0] ramp_reg = 16'h0000;
  logic [2:0]  gate_off_reg = 3'h0;
  // ramp held at valley through the pulse, then climbs one step a cycle
  always @(posedge clk)
    ramp_reg <= osc_pulse ? 16'h0000 : ramp_reg + 16'h0001;
  // low-side gate takes three cycles to decay once its drive is removed
  always @(posedge clk)
    gate_off_reg <= {gate_off_reg[1:0], ~low_gate_en};
  assign low_gate_below_2v = (&gate_off_reg) & ~gate_stuck;
  assign ramp_above_ea     = ea_low | (ramp_reg > ea_thr);
  assign sourcing_current  = high_gate_en & ~sink_mode;
  assign current_limit_cmp = oc_force & high_gate_en;
endmodule : bpc_stage_model
